// >>> hw/sbt_pkg.sv
// Shared constants and types for the memory boundary-scan test port.
// Assumes both ends and the stream buffer import this package.
package sbt_pkg;
   localparam int         IR_W        = 3;
   localparam int         BSR_W       = 75;
   localparam int         ID_W        = 32;
   localparam int         RST_TMS_CNT = 5;
   localparam logic [2:0] IR_EXTEST   = 3'h0;
   localparam logic [2:0] IR_IDCODE   = 3'h1;
   localparam logic [2:0] IR_SAMPZ    = 3'h2;
   localparam logic [2:0] IR_SAMPLE   = 3'h3;
   localparam logic [2:0] IR_BYPASS   = 3'h7;
   localparam logic [1:0] IR_CAPT     = 2'h1;
   localparam logic [31:0] ID_VALUE   = 32'h1234_5679;
   localparam int         TCK_DIV     = 8;
   localparam int         FIFO_DEPTH  = 32;

   typedef enum logic [3:0] {
      ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PA_DR,
      ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR,
      ST_PA_IR, ST_EX2_IR, ST_UPD_IR
   } sbt_tap_e;

   // Standard state walk, used by the port's controller; the master does not track it.
   function automatic sbt_tap_e sbt_next(input sbt_tap_e s, input logic m);
      unique case (s)
         ST_TLR:    sbt_next = m ? ST_TLR    : ST_RTI;
         ST_RTI:    sbt_next = m ? ST_SEL_DR : ST_RTI;
         ST_SEL_DR: sbt_next = m ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR: sbt_next = m ? ST_EX1_DR : ST_SH_DR;
         ST_SH_DR:  sbt_next = m ? ST_EX1_DR : ST_SH_DR;
         ST_EX1_DR: sbt_next = m ? ST_UPD_DR : ST_PA_DR;
         ST_PA_DR:  sbt_next = m ? ST_EX2_DR : ST_PA_DR;
         ST_EX2_DR: sbt_next = m ? ST_UPD_DR : ST_SH_DR;
         ST_UPD_DR: sbt_next = m ? ST_SEL_DR : ST_RTI;
         ST_SEL_IR: sbt_next = m ? ST_TLR    : ST_CAP_IR;
         ST_CAP_IR: sbt_next = m ? ST_EX1_IR : ST_SH_IR;
         ST_SH_IR:  sbt_next = m ? ST_EX1_IR : ST_SH_IR;
         ST_EX1_IR: sbt_next = m ? ST_UPD_IR : ST_PA_IR;
         ST_PA_IR:  sbt_next = m ? ST_EX2_IR : ST_PA_IR;
         ST_EX2_IR: sbt_next = m ? ST_UPD_IR : ST_SH_IR;
         ST_UPD_IR: sbt_next = m ? ST_SEL_DR : ST_RTI;
      endcase
   endfunction
endpackage

// >>> hw/sbt_if.sv
// Scan link between the test port and the board scan master.
// Assumes the bench resolves the test data out wire from its enable.
`timescale 1ns/1ps
`default_nettype none
interface sbt_if;
   logic tck;
   logic tms;
   logic tdi;
   logic tdo;
   logic tdo_oe;
   modport dev (input tck, input tms, input tdi, output tdo, output tdo_oe);
   modport mst (output tck, output tms, output tdi, input tdo,
                input tdo_oe);
endinterface
`default_nettype wire

// >>> hw/sbt_fifo.sv
// Synchronous valid/ready FIFO used on the master's result path.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module sbt_fifo import sbt_pkg::*; #(
   parameter int W = 1,
   parameter int D = FIFO_DEPTH
) (
   input  wire logic         clk_sys_i,
   input  wire logic         rstn_i,
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   input  wire logic [W-1:0] in_data_i,
   output logic              out_valid_o,
   input  wire logic         out_ready_i,
   output logic [W-1:0]      out_data_o
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW-1:0] wr_ff;
   logic [AW-1:0] rd_ff;
   logic [AW:0]   cnt_ff;
   logic          push;
   logic          pop;

   assign in_ready_o  = cnt_ff != (AW+1)'(D);
   assign out_valid_o = cnt_ff != '0;
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;
   assign out_data_o  = mem[rd_ff];

   always_ff @(posedge clk_sys_i) begin
      if (push) begin
         mem[wr_ff] <= in_data_i;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wr_ff  <= '0;
         rd_ff  <= '0;
         cnt_ff <= '0;
      end else begin
         if (push) begin
            wr_ff <= (wr_ff == AW'(D-1)) ? '0 : wr_ff + 1'b1;
         end
         if (pop) begin
            rd_ff <= (rd_ff == AW'(D-1)) ? '0 : rd_ff + 1'b1;
         end
         cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // sbt_fifo
`default_nettype wire

// >>> hw/sbt_master.sv
// Board-side scan master: makes the test clock, walks TMS, shifts TDI and
// collects TDO bits into a FIFO.
// Assumes one request at a time; sequences are given as bit vectors.
`timescale 1ns/1ps
`default_nettype none
module sbt_master import sbt_pkg::*; #(
   parameter int DIV = TCK_DIV
) (
   input  wire logic        clk_sys_i,
   input  wire logic        rstn_i,
   sbt_if.mst               link,
   input  wire logic        req_valid_i,
   output logic             req_ready_o,
   input  wire logic [7:0]  req_len_i,
   input  wire logic [127:0] req_tms_i,
   input  wire logic [127:0] req_tdi_i,
   output logic             bit_valid_o,
   input  wire logic        bit_ready_i,
   output logic             bit_data_o,
   output logic             busy_o
);
   logic [127:0] tms_ff;
   logic [127:0] tdi_ff;
   logic [7:0]   left_ff;
   logic [7:0]   div_ff;
   logic         tck_ff;
   logic         tdo_s1_ff;
   logic         tdo_s2_ff;
   logic         oe_s1_ff;
   logic         oe_s2_ff;
   logic         fin_ready;
   logic         rise;
   logic         fall;
   logic         stall;

   assign link.tck    = tck_ff;
   assign link.tms    = tms_ff[0];
   assign link.tdi    = tdi_ff[0];
   assign busy_o      = left_ff != '0;
   assign req_ready_o = !busy_o;
   assign rise = busy_o && !tck_ff && div_ff == 8'(DIV/2-1);
   assign fall = tck_ff && div_ff == 8'(DIV/2-1);
   // A full result FIFO holds the test clock low rather than lose a bit.
   assign stall = rise && !fin_ready;

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tdo_s1_ff <= 1'b0;
         tdo_s2_ff <= 1'b0;
         oe_s1_ff  <= 1'b0;
         oe_s2_ff  <= 1'b0;
      end else begin
         tdo_s1_ff <= link.tdo;
         tdo_s2_ff <= tdo_s1_ff;
         oe_s1_ff  <= link.tdo_oe;
         oe_s2_ff  <= oe_s1_ff;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         div_ff <= '0;
         tck_ff <= 1'b0;
      end else if (stall || (!busy_o && !tck_ff)) begin
         div_ff <= '0;
      end else if (div_ff == 8'(DIV/2-1)) begin
         div_ff <= '0;
         tck_ff <= !tck_ff;
      end else begin
         div_ff <= div_ff + 8'd1;
      end
   end

   // TMS/TDI are changed on the falling clock so the device sees them
   // stable at its rising edge.
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tms_ff  <= '1;
         tdi_ff  <= '1;
         left_ff <= '0;
      end else if (req_valid_i && req_ready_o) begin
         tms_ff  <= req_tms_i;
         tdi_ff  <= req_tdi_i;
         left_ff <= req_len_i;
      end else if (fall) begin
         tms_ff  <= {1'b1, tms_ff[127:1]};
         tdi_ff  <= {1'b1, tdi_ff[127:1]};
         left_ff <= left_ff - 8'd1;
      end
   end

   // Only bits the device actually drives are reported. The port answers
   // some clocks after a fall and the pin passes two flip-flops here, so
   // the bit is taken just before the next fall, when it has surely
   // settled; the space was checked at the rise before, so none is lost.
   sbt_fifo #(.W(1), .D(FIFO_DEPTH)) u_fifo (
      .clk_sys_i   (clk_sys_i),
      .rstn_i      (rstn_i),
      .in_valid_i  (fall && oe_s2_ff && fin_ready),
      .in_ready_o  (fin_ready),
      .in_data_i   (tdo_s2_ff),
      .out_valid_o (bit_valid_o),
      .out_ready_i (bit_ready_i),
      .out_data_o  (bit_data_o)
   );
endmodule // sbt_master
`default_nettype wire

// >>> hw/sbt_tap.sv
// Memory-side test access port: controller, instruction, bypass, boundary
// and identification registers, all stepped by edges of the sampled TCK.
// Assumes TCK is well below half the system clock.
`timescale 1ns/1ps
`default_nettype none
module sbt_tap import sbt_pkg::*; #(
   parameter logic [2:0]  C_IDCODE = IR_IDCODE,
   parameter logic [2:0]  C_SAMPLE = IR_SAMPLE,
   parameter logic [2:0]  C_SAMPZ  = IR_SAMPZ,
   parameter logic [2:0]  C_BYPASS = IR_BYPASS,
   // Arbitrary identification value.
   parameter logic [31:0] ID_CODE  = ID_VALUE
) (
   input  wire logic             clk_sys_i,
   input  wire logic             rstn_i,
   sbt_if.dev                    link,
   input  wire logic [BSR_W-1:0] ring_i,
   output logic                  mem_hiz_o,
   output logic [3:0]            tap_state_o
);
   // ------------------------------------------------------------------
   // Pin synchronisers and edge finding
   // ------------------------------------------------------------------
   logic [2:0] tck_ff;
   logic [1:0] tms_ff;
   logic [1:0] tdi_ff;
   logic       tck_rise;
   logic       tck_fall;

   // Undriven pins default high through the bench pull-ups.
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tck_ff <= '0;
         tms_ff <= '1;
         tdi_ff <= '1;
      end else begin
         tck_ff <= {tck_ff[1:0], link.tck};
         tms_ff <= {tms_ff[0], link.tms};
         tdi_ff <= {tdi_ff[0], link.tdi};
      end
   end
   assign tck_rise = tck_ff[1] & ~tck_ff[2];
   assign tck_fall = ~tck_ff[1] & tck_ff[2];

   // ------------------------------------------------------------------
   // Controller
   // ------------------------------------------------------------------
   sbt_tap_e st_ff;
   logic [2:0] ones_ff;

   // Power-on reset puts the controller in reset with TDO floating.
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_ff <= ST_TLR;
      end else if (tck_rise) begin
         st_ff <= sbt_next(st_ff, tms_ff[1]);
      end
   end
   assign tap_state_o = st_ff;

   // The state walk already reaches reset in five TMS-high edges; the
   // counter only loads the IDCODE instruction at that fifth rising edge.
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ones_ff <= '0;
      end else if (tck_rise) begin
         ones_ff <= tms_ff[1] ? ((ones_ff == 3'(RST_TMS_CNT-1)) ? ones_ff
                                 : ones_ff + 3'd1) : 3'd0;
      end
   end
   logic force_tlr;
   assign force_tlr = tck_rise && tms_ff[1]
                      && ones_ff == 3'(RST_TMS_CNT-1);

   // ------------------------------------------------------------------
   // Instruction register
   // ------------------------------------------------------------------
   logic [IR_W-1:0] ir_sh_ff;
   logic [IR_W-1:0] ir_ff;

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ir_sh_ff <= '0;
      end else if (tck_rise) begin
         if (st_ff == ST_CAP_IR) begin
            ir_sh_ff <= {1'b0, IR_CAPT};
         end else if (st_ff == ST_SH_IR) begin
            ir_sh_ff <= {tdi_ff[1], ir_sh_ff[IR_W-1:1]};
         end
      end
   end

   // Applied on the falling edge in Update-IR, as the standard does.
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ir_ff <= C_IDCODE;
      end else if (force_tlr || (tck_fall && st_ff == ST_TLR)) begin
         ir_ff <= C_IDCODE;
      end else if (tck_fall && st_ff == ST_UPD_IR) begin
         ir_ff <= ir_sh_ff;
      end
   end

   // ------------------------------------------------------------------
   // Data registers
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {SEL_BYP, SEL_BSR, SEL_ID} sbt_sel_e;
   sbt_sel_e sel;

   // Reserved codes fall back to bypass so the chain keeps its length.
   always_comb begin
      if (ir_ff == C_IDCODE) begin
         sel = SEL_ID;
      end else if (ir_ff == IR_EXTEST || ir_ff == C_SAMPLE
                   || ir_ff == C_SAMPZ) begin
         sel = SEL_BSR;
      end else begin
         sel = SEL_BYP;
      end
   end

   logic             byp_ff;
   logic [BSR_W-1:0] bsr_ff;
   logic [ID_W-1:0]  id_ff;
   logic             cap_dr;
   logic             sh_dr;
   assign cap_dr = tck_rise && st_ff == ST_CAP_DR;
   assign sh_dr  = tck_rise && st_ff == ST_SH_DR;

   // Only the selected register moves; the others hold.
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         byp_ff <= 1'b0;
      end else if (sel == SEL_BYP && cap_dr) begin
         byp_ff <= 1'b0;
      end else if (sel == SEL_BYP && sh_dr) begin
         byp_ff <= tdi_ff[1];
      end
   end

   // The ring is sampled as is; values in transition are undefined.
   // Update-DR has no effect: nothing here feeds the memory.
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         bsr_ff <= '0;
      end else if (sel == SEL_BSR && cap_dr) begin
         bsr_ff <= ring_i;
      end else if (sel == SEL_BSR && sh_dr) begin
         bsr_ff <= {tdi_ff[1], bsr_ff[BSR_W-1:1]};
      end
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         id_ff <= '0;
      end else if (sel == SEL_ID && cap_dr) begin
         id_ff <= ID_CODE;
      end else if (sel == SEL_ID && sh_dr) begin
         id_ff <= {tdi_ff[1], id_ff[ID_W-1:1]};
      end
   end

   // ------------------------------------------------------------------
   // Test data out and memory output control
   // ------------------------------------------------------------------
   logic tdo_ff;
   logic oe_ff;
   logic lsb;

   always_comb begin
      unique case (sel)
         SEL_ID:  lsb = id_ff[0];
         SEL_BSR: lsb = bsr_ff[0];
         default: lsb = byp_ff;
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tdo_ff <= 1'b0;
         oe_ff  <= 1'b0;
      end else if (tck_fall) begin
         oe_ff  <= st_ff == ST_SH_DR || st_ff == ST_SH_IR;
         tdo_ff <= (st_ff == ST_SH_IR) ? ir_sh_ff[0] : lsb;
      end
   end
   assign link.tdo    = tdo_ff;
   assign link.tdo_oe = oe_ff;

   // The only effect on the memory is floating its outputs.
   assign mem_hiz_o = ir_ff == IR_EXTEST || ir_ff == C_SAMPZ;
endmodule // sbt_tap
`default_nettype wire

// >>> tb/sbt_link_asserts.sv
// Link checker: timing relations on the wires between master and port.
// Assumes the default divider of eight system clocks per test clock.
`timescale 1ns/1ps
`default_nettype none
module sbt_link_asserts (
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic tdo,
   input wire logic tdo_oe
);
   logic       tck_q_ff;
   logic [2:0] ones_ff;

   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rstn_i);

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i)
         tck_q_ff <= 1'b0;
      else
         tck_q_ff <= tck;
   end

   // Counts test clock rises with mode select high, saturating at seven.
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i)
         ones_ff <= 3'h0;
      else if (tck && !tck_q_ff)
         ones_ff <= !tms ? 3'h0 : ones_ff + {2'h0, ones_ff != 3'h7};
   end

   sequence s_tck_high;
      tck [*4] ##1 !tck;
   endsequence
   sequence s_tdo_quiet;
      $stable(tdo) [*4];
   endsequence

   chk_tck_high_width:
      assert property ($rose(tck) |-> s_tck_high)
      else $error("test clock high time is not four system clocks");
   chk_tdo_on_low:
      assert property ($changed(tdo) |-> !tck)
      else $error("test data out moved while test clock high");
   chk_oe_on_low:
      assert property ($changed(tdo_oe) |-> !tck)
      else $error("test data out enable moved while test clock high");
   chk_tdo_stands:
      assert property ($rose(tck) |=> s_tdo_quiet)
      else $error("test data out changed after a rising test clock");
   chk_oe_after_reset:
      assert property ($rose(rstn_i) |-> !tdo_oe [*8])
      else $error("test data out driven right after reset");
   chk_five_ones_reset:
      assert property (ones_ff >= 3'h5 |-> !tdo_oe)
      else $error("test data out driven after five mode-high clocks");
   chk_tms_on_low:
      assert property ($changed(tms) |-> !tck)
      else $error("mode select moved while test clock high");
   chk_tdi_on_low:
      assert property ($changed(tdi) |-> !tck)
      else $error("test data in moved while test clock high");
endmodule // sbt_link_asserts
`default_nettype wire

// >>> tb/tb_sram_boundary_scan_tap.sv
// Bench: master and port face each other; scans run through the master.
// Assumes the package codes and the master's default divider.
`timescale 1ns/1ps
`default_nettype none
module tb_sram_boundary_scan_tap import sbt_pkg::*;;
   // Arbitrary identification value.
   localparam logic [31:0] ID_T = 32'h0A5C_3E71;
   logic             clk_sys_i = 1'b0;
   logic             rstn_i = 1'b0;
   logic             req_valid_i = 1'b0;
   logic             bit_ready_i = 1'b0;
   logic [7:0]       req_len_i = 8'h00;
   logic [127:0]     tv = '1;
   logic [127:0]     dv = '1;
   logic [127:0]     bm = '1;
   logic [127:0]     bd = '1;
   logic [127:0]     got = '0;
   logic [BSR_W-1:0] ring_i = '0;
   logic [15:0]      rd = 16'h0040;
   logic [15:0]      sd = 16'h0040;
   logic             req_ready_o, bit_valid_o, bit_data_o, busy_o;
   logic             mem_hiz_o;
   logic [3:0]       tap_state_o;
   int               nb = 0, k = 0, hold = 0, cyc = 0;
   int               n_mismatch = 0, cmp_count = 0;

   sbt_if link ();
   sbt_master u_sbt_master (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
      .link(link.mst), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
      .req_len_i(req_len_i), .req_tms_i(tv), .req_tdi_i(dv),
      .bit_valid_o(bit_valid_o), .bit_ready_i(bit_ready_i),
      .bit_data_o(bit_data_o), .busy_o(busy_o));
   sbt_tap #(.ID_CODE(ID_T)) u_sbt_tap (.clk_sys_i(clk_sys_i),
      .rstn_i(rstn_i), .link(link.dev), .ring_i(ring_i),
      .mem_hiz_o(mem_hiz_o), .tap_state_o(tap_state_o));
   sbt_link_asserts u_sbt_link_asserts (.clk_sys_i(clk_sys_i),
      .rstn_i(rstn_i), .tck(link.tck), .tms(link.tms), .tdi(link.tdi),
      .tdo(link.tdo), .tdo_oe(link.tdo_oe));

   always #2.5 clk_sys_i = ~clk_sys_i;

   function automatic logic [15:0] step(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   function automatic logic [127:0] expv(input int len, input int n,
                                         input logic [127:0] cap, d);
      logic [127:0] e;
      e = '0;
      for (int i = 0; i < n; i++)
         e[i] = (i < len) ? cap[i] : d[i - len];
      return e;
   endfunction

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [127:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Collects returned bits; a hold window starves the buffer so it fills.
   always @(posedge clk_sys_i) begin
      rd <= step(rd);
      bit_ready_i <= (hold == 0) && (rd[0] || rd[3]);
      if (bit_valid_o && bit_ready_i) begin
         got[nb] <= bit_data_o;
         nb <= nb + 1;
      end
      if (hold > 0)
         hold <= hold - 1;
      if (hold == 100)
         chk("stall", {busy_o, link.tck}, 2'b10);
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         n_mismatch++;
         report_and_stop();
      end
   end

   task automatic rnd(output logic [127:0] v);
      for (int i = 0; i < 8; i++) begin
         sd = step(sd);
         v[i*16 +: 16] = sd;
      end
   endtask

   task automatic put(input logic m, input logic d);
      bm[k] = m;
      bd[k] = d;
      k++;
   endtask

   task automatic go(input int nexp);
      int w;
      @(negedge clk_sys_i);
      nb = 0;
      got = '0;
      @(posedge clk_sys_i);
      tv <= bm;
      dv <= bd;
      req_len_i <= 8'(k);
      req_valid_i <= 1'b1;
      @(posedge clk_sys_i);
      req_valid_i <= 1'b0;
      w = 0;
      do begin
         @(negedge clk_sys_i);
         w++;
      end while ((busy_o !== 1'b0 || bit_valid_o !== 1'b0) && w < 9000);
      repeat (4) @(negedge clk_sys_i);
      chk("bits", 128'(nb), 128'(nexp));
      k = 0;
      bm = '1;
      bd = '1;
   endtask

   // Starts from idle or reset, shifts n bits, ends in idle.
   task automatic scan(input bit ir, input int n, input logic [127:0] d);
      put(1'b0, 1'b1);
      put(1'b1, 1'b1);
      if (ir)
         put(1'b1, 1'b1);
      put(1'b0, 1'b1);
      put(1'b0, 1'b1);
      for (int i = 0; i < n; i++)
         put(i == n - 1, d[i]);
      put(1'b1, 1'b1);
      put(1'b0, 1'b1);
      go(n);
   endtask

   initial begin
      int           len;
      bit           bsr;
      logic [2:0]   cd;
      logic [127:0] d, d2, cap;
      repeat (3) @(posedge clk_sys_i);
      rstn_i <= 1'b1;
      @(negedge clk_sys_i);
      chk("oe", link.tdo_oe, 1'b0);
      chk("state", tap_state_o, ST_TLR);
      chk("hiz", mem_hiz_o, 1'b0);
      chk("tck", link.tck, 1'b0);
      rnd(d);
      scan(1'b0, 37, d);
      chk("id", got, expv(ID_W, 37, ID_T, d));
      for (int c = 0; c < 8; c++) begin
         cd = 3'(c);
         rnd(d);
         @(posedge clk_sys_i);
         ring_i <= d[BSR_W-1:0];
         rnd(d2);
         scan(1'b1, IR_W, 128'(cd));
         chk("ircap", got[1:0], IR_CAPT);
         chk("hiz", mem_hiz_o,
             cd == IR_EXTEST || cd == IR_SAMPZ);
         chk("state", tap_state_o, ST_RTI);
         bsr = cd == IR_EXTEST || cd == IR_SAMPZ || cd == IR_SAMPLE;
         len = cd == IR_IDCODE ? ID_W : bsr ? BSR_W : 1;
         cap = cd == IR_IDCODE ? 128'(ID_T) : bsr ? d : '0;
         if (cd == IR_SAMPLE)
            hold = 2000;
         scan(1'b0, len + 5, d2);
         chk("dr", got,
             expv(len, len + 5, cap, d2));
      end
      // Five mode-high clocks from inside an instruction shift.
      put(1'b0, 1'b1);
      put(1'b1, 1'b1);
      put(1'b1, 1'b1);
      put(1'b0, 1'b1);
      put(1'b0, 1'b1);
      repeat (5) put(1'b1, 1'b0);
      go(1);
      chk("state", tap_state_o, ST_TLR);
      rnd(d);
      scan(1'b0, 34, d);
      chk("id", got, expv(ID_W, 34, ID_T, d));
      report_and_stop();
   end
endmodule // tb_sram_boundary_scan_tap
`default_nettype wire
